// *** hdl/fmsp_uart.sv ***
// Overview of operation
// RL1 - both mode bits clear: 8-bit shift register on receive pin, clock on transmit pin
// RL2 - shift-register receive starts only with receive enable 1 and receive flag 0
// RL3 - shift-register bit rate is core clock divided by twelve, fixed
// RL4 - mode 1 frame: start 0, eight data bits LSB first, stop 1
// RL5 - any data buffer write starts transmit; mode 1 loads stop 1 as ninth bit
// RL6 - async modes set transmit flag when stop bit starts on the pin
// RL7 - async receiver detects falling edge, skips start, shifts eight data bits
// RL8 - async receive starts on start bit only while receive enable is set
// RL9 - mode 1 frame end: data to buffer, stop bit to received ninth bit
// RL10 - receive flag set only if flag 0 and multiprocessor off or stop 1
// RL11 - modes 2 and 3: eleven-bit frame with software ninth bit
// RL12 - mode 2 rate core clock over 64, or over 32 with double rate
// RL13 - 9-bit transmit loads data and ninth bit, starts at next bit boundary
// RL14 - 9-bit receive: data to buffer, ninth bit to received ninth bit flag
// RL15 - 9-bit modes with multiprocessor enable: no receive flag if ninth bit 0
// RL16 - mode 3 uses 9-bit framing with timer-derived bit rate
// RL17 - timer 1 rate: two to double-rate bit over 32 times overflow rate
// RL18 - software picks timer 1 reload to reach the wanted rate
// RL19 - timer 1 interrupt should stay off while it makes the rate
// RL20 - timer 2 rate: sixteen overflows per bit
// RL21 - timer 2 counts every two core clocks from its 16-bit reload value
// RL22 - receive and transmit clock selects pick timer 2 independently
// RL23 - start bit checked at mid-bit; line high again abandons reception
module fmsp_uart
    import fmsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire fmsp_bus_req_t reg_req,
    output logic [7:0] reg_rdata,
    // timer 1 overflow pulse from outside
    input wire logic timer1_overflow,
    // serial pins
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_n,
    output logic txd
);

    fmsp_state_t s;
    fmsp_state_t next_s;

    logic [1:0] mode;
    logic mode_shift;
    logic mode_uart8;
    logic wr_ctrl;
    logic wr_data;
    logic fixed_tick;
    logic t1_tick;
    logic t2_on;
    logic t2_ovf;
    logic rx_tick;
    logic tx_tick;
    logic [3:0] tx_last;
    logic [8:0] rx_new;

    assign mode = {s.ctrl[CTRL_SM_HI], s.ctrl[CTRL_SM_LO]};
    assign mode_shift = (mode == MODE_SHIFT);
    assign mode_uart8 = (mode == MODE_UART8);
    assign wr_ctrl = reg_req.wr && (reg_req.addr == OFS_CTRL);
    assign wr_data = reg_req.wr && (reg_req.addr == OFS_DATA);

    // RL12 fixed prescaler: 16 ticks of 4 or 2 core clocks per bit
    assign fixed_tick = (s.pre == 2'h0);

    // RL17 timer 1 overflow halved unless double rate is set
    assign t1_tick = timer1_overflow && (s.double_rate_bit || s.t1_half);

    // RL21 timer 2 advances every second core clock
    assign t2_on = s.rclk || s.transmit_clock_select;
    assign t2_ovf = t2_on && s.t2_half && (s.t2_count == T2_TOP);

    // RL22 per-direction tick source
    // RL20 overflow is one tick
    // RL16 mode 3 timer rate
    assign rx_tick = (mode == MODE_FIX9) ? fixed_tick : (s.rclk ? t2_ovf : t1_tick);
    assign tx_tick = (mode == MODE_FIX9) ? fixed_tick : (s.transmit_clock_select ? t2_ovf : t1_tick);

    // RL4 ten-bit frame
    // RL11 eleven-bit frame
    assign tx_last = mode_uart8 ? TX_LAST_8 : TX_LAST_9;
    assign rx_new = {rxd_in, s.rx_shift[8:1]};

    always_comb begin
        next_s = s;

        // register writes first, so that hardware flag sets below win
        if (wr_ctrl) begin
            next_s.ctrl = reg_req.wdata;
        end
        if (reg_req.wr && (reg_req.addr == OFS_POWER)) begin
            next_s.double_rate_bit = reg_req.wdata[POWER_DOUBLE];
        end
        if (reg_req.wr && (reg_req.addr == OFS_T2CTRL)) begin
            next_s.rclk = reg_req.wdata[T2CTRL_RCLK];
            next_s.transmit_clock_select = reg_req.wdata[T2CTRL_TRANSMIT_CLOCK_SELECT];
        end
        if (reg_req.wr && (reg_req.addr == OFS_T2RLD_LO)) begin
            next_s.t2_reload[7:0] = reg_req.wdata;
        end
        if (reg_req.wr && (reg_req.addr == OFS_T2RLD_HI)) begin
            next_s.t2_reload[15:8] = reg_req.wdata;
        end

        // read data stand only in the cycle after the strobe
        next_s.rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFS_CTRL: next_s.rdata = s.ctrl;
                OFS_DATA: next_s.rdata = s.rx_buf;
                OFS_POWER: next_s.rdata = {s.double_rate_bit, 7'h00};
                OFS_T2CTRL: next_s.rdata = {2'h0, s.rclk, s.transmit_clock_select, 4'h0};
                OFS_T2RLD_LO: next_s.rdata = s.t2_reload[7:0];
                OFS_T2RLD_HI: next_s.rdata = s.t2_reload[15:8];
                default: next_s.rdata = 8'h00;
            endcase
        end

        // fixed-rate prescaler
        if (s.pre == 2'h0) begin
            next_s.pre = s.double_rate_bit ? FIX_PRE_FAST : FIX_PRE_SLOW;
        end else begin
            next_s.pre = s.pre - 2'h1;
        end

        if (timer1_overflow) begin
            next_s.t1_half = ~s.t1_half;
        end

        // RL21 timer 2 reload counter, stopped when neither direction uses it
        if (t2_on) begin
            next_s.t2_half = ~s.t2_half;
            if (s.t2_half) begin
                next_s.t2_count = (s.t2_count == T2_TOP) ? s.t2_reload : s.t2_count + 16'h1;
            end
        end else begin
            next_s.t2_half = 1'b0;
            next_s.t2_count = s.t2_reload;
        end

        // asynchronous transmitter; sub counter runs free so bit edges stay aligned
        if (tx_tick) begin
            next_s.tx_sub = s.tx_sub + 4'h1;
        end
        case (s.tx_st)
            TX_IDLE: begin
                // the shift engine owns the pin while it runs in mode 0
                if (s.m0_st == M0_IDLE) begin
                    next_s.txd = 1'b1;
                end
            end
            TX_WAIT: begin
                // RL13 shifting begins at the next bit boundary
                if (tx_tick && (s.tx_sub == SUB_LAST)) begin
                    next_s.txd = s.tx_frame[0];
                    next_s.tx_frame = {1'b1, s.tx_frame[10:1]};
                    next_s.tx_idx = 4'h0;
                    next_s.tx_st = TX_SEND;
                end
            end
            TX_SEND: begin
                if (tx_tick && (s.tx_sub == SUB_LAST)) begin
                    if (s.tx_idx == tx_last) begin
                        next_s.txd = 1'b1;
                        next_s.tx_st = TX_IDLE;
                    end else begin
                        next_s.txd = s.tx_frame[0];
                        next_s.tx_frame = {1'b1, s.tx_frame[10:1]};
                        next_s.tx_idx = s.tx_idx + 4'h1;
                        // RL6 flag rises with the first cycle of the stop bit
                        if ((s.tx_idx + 4'h1) == tx_last) begin
                            next_s.ctrl[CTRL_TI] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_s.tx_st = TX_IDLE;
            end
        endcase

        // asynchronous receiver
        next_s.rxd_prev = rxd_in;
        case (s.rx_st)
            RX_IDLE: begin
                // RL7 falling edge
                // RL8 receive enable gate
                if (!mode_shift && s.ctrl[CTRL_REN] && s.rxd_prev && !rxd_in) begin
                    next_s.rx_st = RX_START;
                    next_s.rx_sub = 4'h0;
                end
            end
            RX_START: begin
                if (rx_tick) begin
                    next_s.rx_sub = s.rx_sub + 4'h1;
                    // RL23 mid-bit check of the start bit
                    if (s.rx_sub == SUB_MID) begin
                        if (rxd_in) begin
                            next_s.rx_st = RX_IDLE;
                        end else begin
                            next_s.rx_sub = 4'h0;
                            next_s.rx_idx = 4'h0;
                            next_s.rx_st = RX_DATA;
                        end
                    end
                end
            end
            RX_DATA: begin
                if (rx_tick) begin
                    next_s.rx_sub = s.rx_sub + 4'h1;
                    if (s.rx_sub == SUB_LAST) begin
                        // RL7 data bits enter LSB first
                        next_s.rx_shift = rx_new;
                        next_s.rx_idx = s.rx_idx + 4'h1;
                        if (s.rx_idx == RX_LAST) begin
                            next_s.rx_st = RX_IDLE;
                            // RL10 flag free check
                            // RL15 ninth bit filter
                            if (!s.ctrl[CTRL_RI] && (!s.ctrl[CTRL_SM2] || rx_new[8])) begin
                                // RL9 stop to flag
                                // RL14 ninth to flag
                                next_s.rx_buf = rx_new[7:0];
                                next_s.ctrl[CTRL_RB8] = rx_new[8];
                                next_s.ctrl[CTRL_RI] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                next_s.rx_st = RX_IDLE;
            end
        endcase

        // RL1 shift-register engine
        // RL3 twelve clocks per bit
        case (s.m0_st)
            M0_IDLE: begin
                next_s.txd = (s.tx_st == TX_IDLE) ? 1'b1 : next_s.txd;
                next_s.rxd_oe_n = 1'b1;
                // RL2 receive waits for enable set and flag clear
                // a control write may be dropping receive enable, so wait a cycle
                if (mode_shift && !wr_data && !wr_ctrl &&
                    s.ctrl[CTRL_REN] && !next_s.ctrl[CTRL_RI]) begin
                    next_s.m0_st = M0_RX;
                    next_s.m0_cnt = 4'h0;
                    next_s.m0_idx = 3'h0;
                    next_s.txd = 1'b0;
                end
            end
            M0_TX, M0_RX: begin
                next_s.m0_cnt = s.m0_cnt + 4'h1;
                if (s.m0_cnt == M0_CNT_RISE) begin
                    next_s.txd = 1'b1;
                    if (s.m0_st == M0_RX) begin
                        next_s.m0_shift = {rxd_in, s.m0_shift[7:1]};
                    end
                end
                if (s.m0_cnt == M0_CNT_LAST) begin
                    next_s.m0_cnt = 4'h0;
                    next_s.m0_idx = s.m0_idx + 3'h1;
                    if (s.m0_st == M0_TX) begin
                        next_s.m0_shift = {1'b1, s.m0_shift[7:1]};
                        next_s.rxd_out = s.m0_shift[1];
                    end
                    next_s.txd = 1'b0;
                    if (s.m0_idx == M0_LAST_BIT) begin
                        next_s.m0_st = M0_IDLE;
                        next_s.txd = 1'b1;
                        next_s.rxd_oe_n = 1'b1;
                        next_s.rxd_out = 1'b1;
                        if (s.m0_st == M0_TX) begin
                            next_s.ctrl[CTRL_TI] = 1'b1;
                        end else begin
                            next_s.rx_buf = s.m0_shift;
                            next_s.ctrl[CTRL_RI] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                next_s.m0_st = M0_IDLE;
            end
        endcase

        // a mode change drops whatever frame is in flight, since framing and
        // pin roles differ between modes; flags take the control write unless an engine sets one in the same cycle
        if (wr_ctrl && (reg_req.wdata[CTRL_SM_HI:CTRL_SM_LO] != mode)) begin
            next_s.tx_st = TX_IDLE;
            next_s.rx_st = RX_IDLE;
            next_s.m0_st = M0_IDLE;
            next_s.txd = 1'b1;
            next_s.rxd_out = 1'b1;
            next_s.rxd_oe_n = 1'b1;
        end

        // RL5 a data buffer write starts transmission in every mode
        if (wr_data) begin
            if (mode_shift) begin
                // RL1 data leaves on the receive pin, clock on the transmit pin
                next_s.m0_st = M0_TX;
                next_s.m0_cnt = 4'h0;
                next_s.m0_idx = 3'h0;
                next_s.m0_shift = reg_req.wdata;
                next_s.rxd_out = reg_req.wdata[0];
                next_s.rxd_oe_n = 1'b0;
                next_s.txd = 1'b0;
            end else begin
                // RL5 mode 1 stop bit
                // RL13 software ninth bit
                next_s.tx_frame = {1'b1, (mode_uart8 ? 1'b1 : s.ctrl[CTRL_TB8]),
                                   reg_req.wdata, 1'b0};
                next_s.tx_st = TX_WAIT;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.ctrl <= CTRL_RST;
            s.rx_buf <= DATA_RST;
            s.t2_reload <= T2RLD_RST;
            s.t2_count <= T2RLD_RST;
            s.tx_st <= TX_IDLE;
            s.tx_frame <= '1;
            s.rx_st <= RX_IDLE;
            s.rxd_prev <= 1'b1;
            s.m0_st <= M0_IDLE;
            s.txd <= 1'b1;
            s.rxd_out <= 1'b1;
            s.rxd_oe_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign reg_rdata = s.rdata;
    assign rxd_out = s.rxd_out;
    assign rxd_oe_n = s.rxd_oe_n;
    assign txd = s.txd;

endmodule

// *** hdl/fmsp_pkg.sv ***
package fmsp_pkg;

    // register offsets on the plain register port
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_DATA = 3'h1;
    localparam logic [2:0] OFS_POWER = 3'h2;
    localparam logic [2:0] OFS_T2CTRL = 3'h3;
    localparam logic [2:0] OFS_T2RLD_LO = 3'h4;
    localparam logic [2:0] OFS_T2RLD_HI = 3'h5;

    // serial_control_reg fields
    localparam int CTRL_RI = 0;
    localparam int CTRL_TI = 1;
    localparam int CTRL_RB8 = 2;
    localparam int CTRL_TB8 = 3;
    localparam int CTRL_REN = 4;
    localparam int CTRL_SM2 = 5;
    localparam int CTRL_SM_LO = 6;
    localparam int CTRL_SM_HI = 7;

    // power_control_reg and timer2_control_reg fields
    localparam int POWER_DOUBLE = 7;
    localparam int T2CTRL_RCLK = 5;
    localparam int T2CTRL_TRANSMIT_CLOCK_SELECT = 4;

    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [15:0] T2RLD_RST = 16'h0000;

    // mode codes as {mode_select_hi, mode_select_lo}
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_FIX9 = 2'h2;

    // timing counts, in core clocks or in sixteen-times ticks
    localparam int M0_DIV = 12;
    localparam logic [3:0] M0_CNT_LAST = 4'(M0_DIV - 1);
    localparam logic [3:0] M0_CNT_RISE = 4'(M0_DIV / 2);
    localparam logic [2:0] M0_LAST_BIT = 3'h7;
    localparam logic [1:0] FIX_PRE_SLOW = 2'h3;
    localparam logic [1:0] FIX_PRE_FAST = 2'h1;
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_MID = 4'h7;
    localparam logic [3:0] TX_LAST_8 = 4'h9;
    localparam logic [3:0] TX_LAST_9 = 4'hA;
    localparam logic [3:0] RX_LAST = 4'h8;
    localparam logic [15:0] T2_TOP = 16'hFFFF;

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SEND} fmsp_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} fmsp_rx_st_t;
    typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} fmsp_m0_st_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } fmsp_bus_req_t;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] rx_buf;
        logic double_rate_bit;
        logic rclk;
        logic transmit_clock_select;
        logic [15:0] t2_reload;
        logic [15:0] t2_count;
        logic t2_half;
        logic [1:0] pre;
        logic t1_half;
        fmsp_tx_st_t tx_st;
        logic [10:0] tx_frame;
        logic [3:0] tx_idx;
        logic [3:0] tx_sub;
        fmsp_rx_st_t rx_st;
        logic [8:0] rx_shift;
        logic [3:0] rx_idx;
        logic [3:0] rx_sub;
        logic rxd_prev;
        fmsp_m0_st_t m0_st;
        logic [3:0] m0_cnt;
        logic [2:0] m0_idx;
        logic [7:0] m0_shift;
        logic txd;
        logic rxd_out;
        logic rxd_oe_n;
        logic [7:0] rdata;
    } fmsp_state_t;

endpackage

// *** verif/fmsp_serial_peer.sv ***
module fmsp_serial_peer (
    // clock
    input wire logic sys_clk,
    // serial pins
    input wire logic txd,
    input wire logic rxd_oe_n,
    input wire logic rxd_out,
    output logic peer_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] m0_got = 8'h00;
    logic [7:0] m0_src = 8'hFF;
    logic m0_mode = 1'b0;
    logic a_line = 1'b1;
    // line has a pull-up, so a finished shift source reads high
    assign peer_line = m0_mode ? m0_src[0] : a_line;
    always @(posedge txd) begin
        if (!rxd_oe_n) m0_got <= {rxd_out, m0_got[7:1]};
        else m0_src <= {1'b1, m0_src[7:1]};
    end
    task automatic send(input logic [10:0] bits, input int n, input int clks);
        for (int i = 0; i < n; i++) begin
            a_line <= bits[i];
            repeat (clks) @(posedge sys_clk);
        end
        a_line <= 1'b1;
    endtask
    task automatic capture(input int n, input int clks, output logic [10:0] v, output logic ok);
        v = '1;
        ok = 1'b0;
        // sample on the falling edge, away from the edge that launches the pin
        for (int t = 0; t < 40000 && !ok; t++) begin
            @(negedge sys_clk);
            if (txd === 1'b0) ok = 1'b1;
        end
        repeat (clks / 2) @(negedge sys_clk);
        for (int i = 0; i < n; i++) begin
            v[i] = txd;
            if (i < n - 1) repeat (clks) @(negedge sys_clk);
        end
    endtask
endmodule

// *** verif/fmsp_uart_checker.sv ***
module fmsp_uart_checker
    import fmsp_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // register port
    input wire fmsp_bus_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    // serial pins
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic txd
);
    logic [1:0] mode;
    // mode shadow; mid-frame mode changes are not covered
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) mode <= MODE_SHIFT;
        else if (reg_req.wr && reg_req.addr == OFS_CTRL) mode <= reg_req.wdata[7:6];
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    unmapped_read_a: assert property ($past(reg_req.rd) && $past(reg_req.addr) > OFS_T2RLD_HI
        |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
    shift_low_a: assert property (mode == MODE_SHIFT && $fell(txd) |-> !txd [*7] ##1 txd)
        else $error("shift clock low phase wrong");
    shift_high_a: assert property (mode == MODE_SHIFT && $rose(txd) |-> txd [*5])
        else $error("shift clock high phase wrong");
    oe_mode_a: assert property (!rxd_oe_n |-> mode == MODE_SHIFT)
        else $error("receive pin driven outside shift mode");
    data_stable_a: assert property (!rxd_oe_n && !$past(rxd_oe_n) && $changed(rxd_out)
        |-> $fell(txd)) else $error("shift data moved off bit start");
    oe_release_a: assert property ($rose(rxd_oe_n) |-> txd ##1 txd)
        else $error("shift clock not idle after transfer");
    start_len_a: assert property (mode != MODE_SHIFT && $fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    cover property (mode == MODE_SHIFT && $fell(rxd_oe_n));
    cover property (mode != MODE_SHIFT && $fell(txd));
    cover property ($past(reg_req.rd) && reg_rdata != 8'h00);
endmodule

bind fmsp_uart fmsp_uart_checker chk_u (.sys_clk(sys_clk), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .txd(txd));

// *** verif/tb_top.sv ***
module tb_top import fmsp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    fmsp_bus_req_t req = '0;
    logic [7:0] rdata;
    logic t1_ovf = 1'b0;
    int t1_cnt = 0;
    wire logic rxd_in;
    logic rxd_out, rxd_oe_n, txd, peer_line;
    int fails = 0;
    int cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    // overflow every second clock, no timer interrupt involved
    always @(posedge sys_clk) begin
        t1_cnt <= (t1_cnt == 1) ? 0 : 1;
        t1_ovf <= (t1_cnt == 1);
    end
    assign rxd_in = (rxd_oe_n === 1'b0) ? rxd_out : peer_line;
    fmsp_uart dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
        .timer1_overflow(t1_ovf), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n),
        .txd(txd));
    fmsp_serial_peer peer_u (.sys_clk(sys_clk), .txd(txd), .rxd_oe_n(rxd_oe_n),
        .rxd_out(rxd_out), .peer_line(peer_line));
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        #1 v = rdata;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    task automatic cap(input int n, input int clks, output logic [10:0] v);
        logic ok;
        peer_u.capture(n, clks, v, ok);
        check(ok, 11'h001);
        // a frame that never started ends the run
        if (ok !== 1'b1) test_done();
    endtask
    task automatic wait_ctrl(input int idx);
        logic [7:0] v;
        for (int i = 0; i < 3000; i++) begin
            rd(OFS_CTRL, v);
            if (v[idx] === 1'b1) return;
        end
        fails++;
        test_done();
    endtask
    initial begin
        logic [10:0] f;
        logic [7:0] v;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        check(txd, 11'h001);
        check(rxd_oe_n, 11'h001);
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(OFS_DATA, DATA_RST);
        wr(3'h7, 8'hFF);
        rdchk(3'h7, 8'h00);
        $display("end of test 1");
        wr(OFS_CTRL, 8'h00);
        wr(OFS_DATA, 8'hA5);
        wait_ctrl(CTRL_TI);
        check(peer_u.m0_got, 8'hA5);
        check(rxd_oe_n, 11'h001);
        peer_u.m0_mode = 1'b1;
        peer_u.m0_src = 8'h3C;
        wr(OFS_CTRL, 8'h10);
        wait_ctrl(CTRL_RI);
        rdchk(OFS_DATA, 8'h3C);
        peer_u.m0_src = 8'h00;
        repeat (40) @(posedge sys_clk);
        check(peer_u.m0_src, 8'h00);
        wr(OFS_CTRL, 8'h00);
        peer_u.m0_mode = 1'b0;
        $display("end of test 2");
        for (int d = 0; d < 2; d++) begin
            v = d ? 8'h5B : 8'h5A;
            wr(OFS_POWER, d ? 8'h80 : 8'h00);
            wr(OFS_CTRL, d ? 8'h88 : 8'h80);
            wr(OFS_DATA, v);
            cap(11, d ? 32 : 64, f);
            check(f, {1'b1, d[0], v, 1'b0});
            wait_ctrl(CTRL_TI);
        end
        $display("end of test 3");
        wr(OFS_CTRL, 8'h40);
        wr(OFS_DATA, 8'hC3);
        cap(10, 32, f);
        check(f, {2'h3, 8'hC3, 1'b0});
        wr(OFS_CTRL, 8'h40);
        peer_u.send({2'h3, 8'h96, 1'b0}, 10, 32);
        repeat (40) @(posedge sys_clk);
        rdchk(OFS_CTRL, 8'h40);
        wr(OFS_CTRL, 8'h50);
        peer_u.send(11'h7FE, 1, 8);
        repeat (64) @(posedge sys_clk);
        rdchk(OFS_CTRL, 8'h50);
        peer_u.send({2'h3, 8'h96, 1'b0}, 10, 32);
        wait_ctrl(CTRL_RI);
        rdchk(OFS_DATA, 8'h96);
        rdchk(OFS_CTRL, 8'h55);
        peer_u.send({2'h3, 8'h11, 1'b0}, 10, 32);
        repeat (40) @(posedge sys_clk);
        rdchk(OFS_DATA, 8'h96);
        wr(OFS_CTRL, 8'h70);
        peer_u.send({2'h0, 8'h22, 1'b0}, 10, 32);
        repeat (40) @(posedge sys_clk);
        rdchk(OFS_CTRL, 8'h70);
        $display("end of test 4");
        wr(OFS_T2RLD_LO, 8'hFE);
        wr(OFS_T2RLD_HI, 8'hFF);
        rdchk(OFS_T2RLD_LO, 8'hFE);
        wr(OFS_T2CTRL, 8'h20);
        wr(OFS_CTRL, 8'hF0);
        peer_u.send({2'h2, 8'h44, 1'b0}, 11, 64);
        repeat (80) @(posedge sys_clk);
        rdchk(OFS_CTRL, 8'hF0);
        peer_u.send({2'h3, 8'hA7, 1'b0}, 11, 64);
        wait_ctrl(CTRL_RI);
        rdchk(OFS_DATA, 8'hA7);
        rdchk(OFS_CTRL, 8'hF5);
        wr(OFS_CTRL, 8'hC0);
        wr(OFS_DATA, 8'h3C);
        cap(11, 32, f);
        check(f, {2'h2, 8'h3C, 1'b0});
        $display("end of test 5");
        test_done();
    end
endmodule
